/* File: common/urm_defs.vh */
// Constants for the UART register map, FIFO status and interrupt block.
// Assumes a 3-bit register address and 8-bit data bus.
`ifndef URM_DEFS_VH
`define URM_DEFS_VH

// ==========================================================
// Register addresses
`define URM_A_DATA     3'h0
`define URM_A_IEN      3'h1
`define URM_A_ISTAT    3'h2
`define URM_A_LCTL     3'h3
`define URM_A_MCTL     3'h4
`define URM_A_LSTAT    3'h5
`define URM_A_MSTAT    3'h6
`define URM_A_SCR      3'h7
`define URM_A_RES1     3'h4
`define URM_A_RES2     3'h5
`define URM_A_PAU1     3'h6
`define URM_A_PAU2     3'h7

// ==========================================================
// Field positions and codes
`define URM_LCTL_DIV   7
`define URM_LCTL_ENH   8'hbf
`define URM_EFN_EXT    4
`define URM_FCTL_EN    0
`define URM_FCTL_RXRST 1
`define URM_FCTL_TXRST 2
`define URM_IEN_BASE   8'h0f
`define URM_MCTL_BASE  8'h1f
`define URM_FCTL_BASE  8'hcf
`define URM_IS_NONE    6'h01
`define URM_IS_LINE    6'h06
`define URM_IS_RXDATA  6'h04
`define URM_IS_TXRDY   6'h02
`define URM_IS_MODEM   6'h00

// ==========================================================
// Reset values and identity (identity value arbitrary)
`define URM_RST_BYTE   8'h00
`define URM_RST_LCTL   8'h03
`define URM_RST_TRIG   8'h01
`define URM_REVISION   8'h01
`define URM_IDENT      8'h5a

// ==========================================================
// FIFO size
`define URM_FIFO_W     11
`define URM_FIFO_D     8
`define URM_FIFO_AW    3

`endif

/* File: core/urm_fifo.v */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock, synchronous active-high reset and flush.
module urm_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  input  wire             flush,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data,
  // Fill level
  output reg  [AW:0]      count
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  wire            do_wr;
  wire            do_rd;

  // Handshakes
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  // Storage write
  always @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // Head word registered, looking past this cycle's pop and push
  wire [AW-1:0] nxt_rd = do_rd ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
  always @(posedge clk) begin
    if (do_wr & (wr_ptr_ff == nxt_rd)) begin
      out_data <= in_data;
    end else begin
      out_data <= mem[nxt_rd];
    end
  end

  // Pointers and count
  always @(posedge clk) begin
    if (rst | flush) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd & ~do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // urm_fifo

/* File: core/urm_regmap.v */
// UART channel register map, receive FIFO status and interrupt gating.
// Assumes host bus inputs synchronous to REF_CLK; receive characters
// arrive as pulses with error tags; transmitter reports its state.
`include "urm_defs.vh"
module urm_regmap (
  // Clock and reset
  input  wire       REF_CLK,
  input  wire       RESET,
  // Host register port
  input  wire [2:0] ADDR,
  input  wire       WR_STB,
  input  wire       RD_STB,
  input  wire [7:0] WDATA,
  output reg  [7:0] RDATA,
  // Receive character stream
  input  wire       RX_VALID,
  output wire       RX_READY,
  input  wire [7:0] RX_CHAR,
  input  wire [2:0] RX_ERR,
  // Transmitter state
  input  wire       TX_HOLD_EMPTY,
  input  wire       TX_SHIFT_EMPTY,
  input  wire       TX_WRITE,
  // Modem status change
  input  wire       MODEM_DELTA,
  // Interrupt and controls
  output wire       INT_OUT,
  output wire [15:0] DIVISOR,
  output wire [7:0] LINE_CTL,
  output wire [7:0] MODEM_CTL
);
  // ========================================================
  // Registers
  reg [7:0] ien_ff, lctl_ff, mctl_ff, scr_ff, fctl_ff;
  reg [7:0] dlo_ff, dhi_ff, afn_ff, trig_ff, feat_ff, efn_ff;
  reg [7:0] res1_ff, res2_ff, pau1_ff, pau2_ff;
  reg       ovr_ff;
  reg       txrdy_ff;
  reg       modem_ff;
  reg       line_int_ff;
  reg       txrdy_hold_ff; // Last hold-empty level, for edge detect
  reg       nxt_ovr;
  reg       nxt_txrdy;
  reg       nxt_modem;
  reg       nxt_line;
  wire      ext_on   = efn_ff[`URM_EFN_EXT];
  wire      div_mode = lctl_ff[`URM_LCTL_DIV] &
                       (lctl_ff != `URM_LCTL_ENH);
  wire      enh_mode = (lctl_ff == `URM_LCTL_ENH);
  wire      fifo_on  = fctl_ff[`URM_FCTL_EN];
  wire      div_zero = (dlo_ff == 8'h00) & (dhi_ff == 8'h00);
  wire      wr       = WR_STB;
  wire      rd       = RD_STB;

  // Effective masks: extended bits need enhanced bit 4
  wire [7:0] ien_eff  = ien_ff &
                        (ext_on ? 8'hff : `URM_IEN_BASE);
  wire [7:0] mctl_eff = mctl_ff &
                        (ext_on ? 8'hff : `URM_MCTL_BASE);
  assign LINE_CTL  = lctl_ff;
  assign MODEM_CTL = mctl_eff;
  assign DIVISOR   = {dhi_ff, dlo_ff};

  // ========================================================
  // Receive FIFO: char plus parity, framing, break tags
  wire        rd_data  = rd & (ADDR == `URM_A_DATA) & ~lctl_ff[7];
  wire        rx_flush = wr & (ADDR == `URM_A_ISTAT) & ~lctl_ff[7] &
                         WDATA[`URM_FCTL_EN] & WDATA[`URM_FCTL_RXRST];
  wire        f_valid;
  wire [10:0] f_head;
  wire [3:0]  f_count;
  urm_fifo #(
    .WIDTH (`URM_FIFO_W),
    .DEPTH (`URM_FIFO_D),
    .AW    (`URM_FIFO_AW)
  ) u_rx_fifo (
    .clk       (REF_CLK),
    .rst       (RESET),
    .flush     (rx_flush),
    .in_valid  (RX_VALID),
    .in_ready  (RX_READY),
    .in_data   ({RX_ERR, RX_CHAR}),
    .out_valid (f_valid),
    .out_ready (rd_data),
    .out_data  (f_head),
    .count     (f_count)
  );

  // Error tag summary over stored characters
  reg [3:0] err_cnt_ff;
  wire in_err  = RX_VALID & RX_READY & (|RX_ERR);
  wire out_err = rd_data & f_valid & (|f_head[10:8]);
  always @(posedge REF_CLK) begin
    if (RESET | rx_flush) begin
      err_cnt_ff <= 4'h0;
    end else if (in_err & ~out_err) begin
      err_cnt_ff <= err_cnt_ff + 4'h1;
    end else if (out_err & ~in_err) begin
      err_cnt_ff <= err_cnt_ff - 4'h1;
    end
  end

  // ========================================================
  // Line status composition
  wire       data_rdy = f_valid;
  wire [2:0] head_err = f_valid ? f_head[10:8] : 3'h0;
  wire [7:0] lstat = {
    (err_cnt_ff != 4'h0),
    TX_HOLD_EMPTY & TX_SHIFT_EMPTY,
    TX_HOLD_EMPTY,
    head_err,
    ovr_ff,
    data_rdy
  };

  // Receive trigger: fifo fill vs programmed level
  wire [7:0] fill8   = {4'h0, f_count};
  wire       rx_trig = fifo_on ? (fill8 >= trig_ff) & f_valid
                               : f_valid;

  // ========================================================
  // Interrupt sources gated by enables
  wire src_line = ien_eff[2] & line_int_ff;
  wire src_rx   = ien_eff[0] & rx_trig;
  wire src_tx   = ien_eff[1] & txrdy_ff;
  wire src_mod  = ien_eff[3] & modem_ff;
  reg  [5:0] icode;
  always @* begin
    if (src_line) begin
      icode = `URM_IS_LINE;
    end else if (src_rx) begin
      icode = `URM_IS_RXDATA;
    end else if (src_tx) begin
      icode = `URM_IS_TXRDY;
    end else if (src_mod) begin
      icode = `URM_IS_MODEM;
    end else begin
      icode = `URM_IS_NONE;
    end
  end
  assign INT_OUT = ~icode[0];
  wire [7:0] istat = {fifo_on, fifo_on,
                      icode[5:4] & {2{ext_on}}, icode[3:0]};

  // ========================================================
  // Sticky event flags; set wins over clear
  wire rd_istat = rd & (ADDR == `URM_A_ISTAT) & ~lctl_ff[7];
  wire rd_lstat = rd & (ADDR == `URM_A_LSTAT) & ~lctl_ff[7];
  wire rd_mstat = rd & (ADDR == `URM_A_MSTAT) & ~lctl_ff[7];
  wire wr_thold = wr & (ADDR == `URM_A_DATA) & ~lctl_ff[7];
  wire ovr_evt  = RX_VALID & ~RX_READY;
  wire ien_tx_r = wr & (ADDR == `URM_A_IEN) & ~lctl_ff[7] &
                  WDATA[1] & ~ien_ff[1];
  // Next values of the event flags
  always @* begin
    nxt_ovr   = ovr_evt | (ovr_ff & ~rd_lstat);
    nxt_line  = ovr_evt | in_err | (line_int_ff & ~rd_lstat);
    nxt_modem = MODEM_DELTA | (modem_ff & ~rd_mstat);
    nxt_txrdy = (TX_HOLD_EMPTY & (ien_tx_r | ~txrdy_hold_ff)) |
                (txrdy_ff & ~rd_istat & ~wr_thold & ~TX_WRITE);
  end
  // Event flags; hold-empty history resets high, no false edge
  always @(posedge REF_CLK) begin
    if (RESET) begin
      ovr_ff        <= 1'b0;
      line_int_ff   <= 1'b0;
      modem_ff      <= 1'b0;
      txrdy_ff      <= 1'b0;
      txrdy_hold_ff <= 1'b1;
    end else begin
      ovr_ff        <= nxt_ovr;
      line_int_ff   <= nxt_line;
      modem_ff      <= nxt_modem;
      txrdy_ff      <= nxt_txrdy;
      txrdy_hold_ff <= TX_HOLD_EMPTY;
    end
  end

  // ========================================================
  // Register writes, decoded by access mode
  always @(posedge REF_CLK) begin
    if (RESET) begin
      ien_ff  <= `URM_RST_BYTE;
      lctl_ff <= `URM_RST_LCTL;
      mctl_ff <= `URM_RST_BYTE;
      scr_ff  <= `URM_RST_BYTE;
      fctl_ff <= `URM_RST_BYTE;
      dlo_ff  <= `URM_RST_BYTE;
      dhi_ff  <= `URM_RST_BYTE;
      afn_ff  <= `URM_RST_BYTE;
      trig_ff <= `URM_RST_TRIG;
      feat_ff <= `URM_RST_BYTE;
      efn_ff  <= `URM_RST_BYTE;
      res1_ff <= `URM_RST_BYTE;
      res2_ff <= `URM_RST_BYTE;
      pau1_ff <= `URM_RST_BYTE;
      pau2_ff <= `URM_RST_BYTE;
    end else if (wr) begin
      if (ADDR == `URM_A_LCTL) begin
        lctl_ff <= WDATA;
      end else if (enh_mode & (ADDR == `URM_A_DATA)) begin
        trig_ff <= WDATA;
      end else if (enh_mode & (ADDR == `URM_A_IEN)) begin
        feat_ff <= WDATA;
      end else if (enh_mode & (ADDR == `URM_A_ISTAT)) begin
        efn_ff <= WDATA;
      end else if (enh_mode & (ADDR == `URM_A_RES1)) begin
        res1_ff <= WDATA;
      end else if (enh_mode & (ADDR == `URM_A_RES2)) begin
        res2_ff <= WDATA;
      end else if (enh_mode & (ADDR == `URM_A_PAU1)) begin
        pau1_ff <= WDATA;
      end else if (enh_mode & (ADDR == `URM_A_PAU2)) begin
        pau2_ff <= WDATA;
      end else if (div_mode & (ADDR == `URM_A_DATA)) begin
        dlo_ff <= WDATA;
      end else if (div_mode & (ADDR == `URM_A_IEN)) begin
        dhi_ff <= WDATA;
      end else if (div_mode & (ADDR == `URM_A_ISTAT)) begin
        afn_ff <= {5'h00, WDATA[2:0]};
      end else if (lctl_ff[7]) begin
        scr_ff <= scr_ff;
      end else if (ADDR == `URM_A_IEN) begin
        ien_ff <= WDATA;
      end else if (ADDR == `URM_A_ISTAT) begin
        fctl_ff <= WDATA[0] ? (WDATA & (ext_on ? 8'hff
                   : `URM_FCTL_BASE) & 8'hf9)
                   : `URM_RST_BYTE;
      end else if (ADDR == `URM_A_MCTL) begin
        mctl_ff <= WDATA;
      end else if (ADDR == `URM_A_SCR) begin
        scr_ff <= WDATA;
      end
    end
  end

  // ========================================================
  // Read data, registered on the read strobe
  always @(posedge REF_CLK) begin
    if (RESET) begin
      RDATA <= 8'h00;
    end else if (rd) begin
      if (ADDR == `URM_A_LCTL) begin
        RDATA <= lctl_ff;
      end else if (enh_mode & (ADDR == `URM_A_DATA)) begin
        RDATA <= fill8;
      end else if (enh_mode & (ADDR == `URM_A_IEN)) begin
        RDATA <= feat_ff;
      end else if (enh_mode & (ADDR == `URM_A_ISTAT)) begin
        RDATA <= efn_ff;
      end else if (enh_mode & (ADDR == `URM_A_RES1)) begin
        RDATA <= res1_ff;
      end else if (enh_mode & (ADDR == `URM_A_RES2)) begin
        RDATA <= res2_ff;
      end else if (enh_mode & (ADDR == `URM_A_PAU1)) begin
        RDATA <= pau1_ff;
      end else if (enh_mode & (ADDR == `URM_A_PAU2)) begin
        RDATA <= pau2_ff;
      end else if (div_mode & (ADDR == `URM_A_DATA)) begin
        RDATA <= div_zero ? `URM_REVISION : dlo_ff;
      end else if (div_mode & (ADDR == `URM_A_IEN)) begin
        RDATA <= div_zero ? `URM_IDENT : dhi_ff;
      end else if (div_mode & (ADDR == `URM_A_ISTAT)) begin
        RDATA <= afn_ff;
      end else if (lctl_ff[7]) begin
        RDATA <= 8'h00;
      end else if (ADDR == `URM_A_DATA) begin
        RDATA <= f_head[7:0];
      end else if (ADDR == `URM_A_IEN) begin
        RDATA <= ien_eff;
      end else if (ADDR == `URM_A_ISTAT) begin
        RDATA <= istat;
      end else if (ADDR == `URM_A_MCTL) begin
        RDATA <= mctl_eff;
      end else if (ADDR == `URM_A_LSTAT) begin
        RDATA <= lstat;
      end else if (ADDR == `URM_A_SCR) begin
        RDATA <= scr_ff;
      end else begin
        RDATA <= 8'h00;
      end
    end
  end
endmodule // urm_regmap

/* File: verification/urm_rx_src.sv */
// Line receiver stand-in feeding characters into the block.
// Assumes the bench pulses send for one cycle with char and tags.
module urm_rx_src (
  // Clock and request
  input  logic       clk,
  input  logic       send,
  input  logic [7:0] chr,
  input  logic [2:0] err,
  // Character stream
  output logic       rx_valid,
  output logic [7:0] rx_char,
  output logic [2:0] rx_err
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // Idle state
  initial begin
    rx_valid = 1'b0;
    rx_char  = 8'h00;
    rx_err   = 3'h0;
  end
  // One-cycle offer; a receiver cannot stall, so full loses it
  always @(posedge clk) begin
    rx_valid <= send;
    rx_char  <= send ? chr : ~rx_char;
    rx_err   <= send ? err : ~rx_err;
  end
endmodule // urm_rx_src

/* File: verification/urm_regmap_sva.sv */
// Concurrent checks on the register map block's ports.
// Assumes binding to urm_regmap; one clock, synchronous reset.
`include "urm_defs.vh"
module urm_regmap_sva (
  // Clock and reset
  input wire        REF_CLK,
  input wire        RESET,
  // Host port
  input wire [2:0]  ADDR,
  input wire        WR_STB,
  input wire        RD_STB,
  input wire [7:0]  WDATA,
  input wire [7:0]  RDATA,
  // Block state
  input wire        TX_HOLD_EMPTY,
  input wire        TX_SHIFT_EMPTY,
  input wire        MODEM_DELTA,
  input wire        INT_OUT,
  input wire [15:0] DIVISOR,
  input wire [7:0]  LINE_CTL,
  input wire [7:0]  MODEM_CTL
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // Mirrors of the enable bits and the enhanced bit
  reg  [3:0] ien_ff;
  reg        ext_ff;
  wire       base = !LINE_CTL[7];
  wire       enh  = LINE_CTL == `URM_LCTL_ENH;
  wire       dvm  = LINE_CTL[7] && !enh;
  always @(posedge REF_CLK) begin
    if (RESET) begin
      ien_ff <= 4'h0;
      ext_ff <= 1'b0;
    end else begin
      if (WR_STB && base && ADDR == `URM_A_IEN)
        ien_ff <= WDATA[3:0];
      if (WR_STB && enh && ADDR == 3'h2)
        ext_ff <= WDATA[`URM_EFN_EXT];
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // ======
  // Divisor-mode accesses, then line control, status, interrupt and mask checks
  sequence div_wr(a);
    dvm && WR_STB && ADDR == a;
  endsequence
  sequence id_rd(a);
    dvm && RD_STB && ADDR == a && DIVISOR == 16'h0000;
  endsequence
  lctl_write_a: assert property (
    WR_STB && ADDR == `URM_A_LCTL |=> LINE_CTL == $past(WDATA))
    else $error("line control not written");
  div_low_a: assert property (
    div_wr(3'h0) |=> DIVISOR[7:0] == $past(WDATA))
    else $error("divisor low byte not written");
  div_high_a: assert property (
    div_wr(3'h1) |=> DIVISOR[15:8] == $past(WDATA))
    else $error("divisor high byte not written");
  div_keep_a: assert property (
    !dvm |=> $stable(DIVISOR))
    else $error("divisor changed outside divisor mode");
  rev_read_a: assert property (
    id_rd(3'h0) |=> RDATA == `URM_REVISION)
    else $error("revision byte wrong");
  ident_read_a: assert property (
    id_rd(3'h1) |=> RDATA == `URM_IDENT)
    else $error("ident byte wrong");
  tx_bits_a: assert property (
    RD_STB && base && ADDR == `URM_A_LSTAT |=> RDATA[6:5] ==
      {$past(TX_HOLD_EMPTY && TX_SHIFT_EMPTY), $past(TX_HOLD_EMPTY)})
    else $error("transmit status bits wrong");
  polled_quiet_a: assert property (
    ien_ff == 4'h0 |-> !INT_OUT)
    else $error("interrupt with all enables clear");
  modem_int_a: assert property (
    ien_ff[3] && MODEM_DELTA && !RD_STB && !WR_STB |=> INT_OUT)
    else $error("modem change raised no interrupt");
  mctl_mask_a: assert property (
    !ext_ff |-> MODEM_CTL[7:5] == 3'h0)
    else $error("extended modem bits without enhanced bit");
endmodule // urm_regmap_sva

/* File: verification/tb.sv */
// Self-checking bench for the register map, status and interrupts.
// Assumes urm_regmap, urm_fifo, the source model and checker compiled.
`include "urm_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, wr, rd, send, txh, txs, txw, mdm;
  logic        intr, rdy, rxv;
  logic [2:0]  addr, err, rxe;
  logic [7:0]  wd, rdat, chr, rxc, lctl, mctl;
  logic [15:0] dvs;
  int          errors, check_count;
  urm_regmap DUT (
    .REF_CLK(clk), .RESET(rst), .ADDR(addr), .WR_STB(wr),
    .RD_STB(rd), .WDATA(wd), .RDATA(rdat), .RX_VALID(rxv),
    .RX_READY(rdy), .RX_CHAR(rxc), .RX_ERR(rxe), .TX_HOLD_EMPTY(txh),
    .TX_SHIFT_EMPTY(txs), .TX_WRITE(txw), .MODEM_DELTA(mdm),
    .INT_OUT(intr), .DIVISOR(dvs), .LINE_CTL(lctl), .MODEM_CTL(mctl));
  urm_rx_src u_src (.clk(clk), .send(send), .chr(chr), .err(err),
    .rx_valid(rxv), .rx_char(rxc), .rx_err(rxe));
  // ======
  // Clock and tasks
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chi(input logic e);
    @(posedge clk);
    #1 chk({7'h00, intr}, {7'h00, e});
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    wd = d;
    wr = 1'b1;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    chk(rdat, e);
  endtask
  task automatic rx(input logic [7:0] c, input logic [2:0] e);
    @(posedge clk);
    #1 chr = c;
    err = e;
    send = 1'b1;
    @(posedge clk);
    #1 send = 1'b0;
  endtask
  task automatic pls(ref logic s);
    @(posedge clk);
    #1 s = 1'b1;
    @(posedge clk);
    #1 s = 1'b0;
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles of the tests
  initial begin
    #200000;
    errors++;
    test_done;
  end
  // ======
  // Test sequence
  initial begin
    {wr, rd, send, txw, mdm, txh, txs} = 7'h00;
    {addr, err, wd, chr} = 22'h000000;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    rreg(`URM_A_LCTL, 8'h03);
    rreg(`URM_A_ISTAT, 8'h01);
    txh = 1'b1;
    rreg(`URM_A_LSTAT, 8'h20);
    txs = 1'b1;
    rreg(`URM_A_LSTAT, 8'h60);
    // Divisor map, zero divisor first
    wreg(`URM_A_LCTL, 8'h80);
    rreg(3'h0, `URM_REVISION);
    rreg(3'h1, `URM_IDENT);
    wreg(3'h0, 8'h34);
    wreg(3'h1, 8'h12);
    rreg(3'h0, 8'h34);
    rreg(3'h1, 8'h12);
    wreg(3'h2, 8'hff);
    rreg(3'h2, 8'h07);
    // Enhanced map, trigger level 3
    wreg(`URM_A_LCTL, `URM_LCTL_ENH);
    wreg(3'h2, 8'h10);
    rreg(3'h2, 8'h10);
    wreg(3'h1, 8'ha5);
    rreg(3'h1, 8'ha5);
    for (int i = 4; i < 8; i++) wreg(i[2:0], 8'h40 + i[7:0]);
    for (int i = 4; i < 8; i++) rreg(i[2:0], 8'h40 + i[7:0]);
    wreg(3'h0, 8'h03);
    rreg(3'h0, 8'h00);
    // Polled fifo mode, enables 0-3 clear
    wreg(`URM_A_LCTL, 8'h03);
    wreg(`URM_A_ISTAT, 8'h01);
    rx(8'h11, 3'h0);
    rx(8'h22, 3'h1);
    rx(8'h33, 3'h0);
    chi(1'b0);
    rreg(`URM_A_LSTAT, 8'he1);
    rreg(`URM_A_DATA, 8'h11);
    rreg(`URM_A_LSTAT, 8'he5);
    rreg(`URM_A_DATA, 8'h22);
    rreg(`URM_A_LSTAT, 8'h61);
    // Trigger interrupt rises at 3 and drops below
    wreg(`URM_A_IEN, 8'h01);
    chi(1'b0);
    rx(8'h44, 3'h0);
    rx(8'h55, 3'h0);
    chi(1'b1);
    rreg(`URM_A_ISTAT, 8'hc4);
    rreg(`URM_A_DATA, 8'h33);
    chi(1'b0);
    rreg(`URM_A_ISTAT, 8'hc1);
    // Fill to refusal, then overrun
    for (int i = 0; i < 6; i++) rx(8'h60 + i[7:0], 3'h0);
    rreg(`URM_A_LSTAT, 8'h61);
    chk({7'h00, rdy}, 8'h00);
    rx(8'hee, 3'h4);
    rreg(`URM_A_LSTAT, 8'h63);
    rreg(`URM_A_LSTAT, 8'h61);
    rreg(`URM_A_DATA, 8'h44);
    wreg(`URM_A_ISTAT, 8'h03);
    rreg(`URM_A_LSTAT, 8'h60);
    // Non-fifo mode: one held character interrupts
    wreg(`URM_A_ISTAT, 8'h00);
    rx(8'h77, 3'h0);
    chi(1'b1);
    rreg(`URM_A_ISTAT, 8'h04);
    rreg(`URM_A_DATA, 8'h77);
    chi(1'b0);
    // Errored character raises the line status source
    wreg(`URM_A_IEN, 8'h04);
    rx(8'h88, 3'h2);
    chi(1'b1);
    rreg(`URM_A_ISTAT, 8'h06);
    rreg(`URM_A_LSTAT, 8'he9);
    chi(1'b0);
    rreg(`URM_A_DATA, 8'h88);
    // Modem and transmit sources through their enables
    wreg(`URM_A_IEN, 8'h08);
    pls(mdm);
    chi(1'b1);
    rreg(`URM_A_ISTAT, 8'h00);
    wreg(`URM_A_IEN, 8'h02);
    rreg(`URM_A_ISTAT, 8'h02);
    chi(1'b0);
    wreg(`URM_A_IEN, 8'h00);
    wreg(`URM_A_IEN, 8'h02);
    chi(1'b1);
    pls(txw);
    chi(1'b0);
    // Extended bits with and without the enhanced bit
    wreg(`URM_A_MCTL, 8'hff);
    chk(mctl, 8'hff);
    wreg(`URM_A_IEN, 8'hf0);
    rreg(`URM_A_IEN, 8'hf0);
    wreg(`URM_A_LCTL, `URM_LCTL_ENH);
    wreg(3'h2, 8'h00);
    wreg(`URM_A_LCTL, 8'h03);
    wreg(`URM_A_MCTL, 8'hff);
    chk(mctl, 8'h1f);
    wreg(`URM_A_IEN, 8'hf0);
    rreg(`URM_A_IEN, 8'h00);
    // Mid-run reset restores defaults and quiets the interrupt
    wreg(`URM_A_IEN, 8'h02);
    chi(1'b1);
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk({7'h00, intr}, 8'h00);
    chk(rdat, 8'h00);
    chk(dvs[15:8], 8'h00);
    chk(dvs[7:0], 8'h00);
    rreg(`URM_A_LCTL, `URM_RST_LCTL);
    rreg(`URM_A_LSTAT, 8'h60);
    test_done;
  end
endmodule // tb
bind urm_regmap urm_regmap_sva u_sva (
  .REF_CLK(REF_CLK), .RESET(RESET), .ADDR(ADDR), .WR_STB(WR_STB),
  .RD_STB(RD_STB), .WDATA(WDATA), .RDATA(RDATA),
  .TX_HOLD_EMPTY(TX_HOLD_EMPTY), .TX_SHIFT_EMPTY(TX_SHIFT_EMPTY),
  .MODEM_DELTA(MODEM_DELTA), .INT_OUT(INT_OUT), .DIVISOR(DIVISOR),
  .LINE_CTL(LINE_CTL), .MODEM_CTL(MODEM_CTL));
